// [rsrb_regs.vh]
// register offsets, field positions and bus constants of the radio status register bank
`ifndef RSRB_REGS_VH
`define RSRB_REGS_VH

// status register indices (byte address is four times the index)
`define RSRB_IDX_WAKE_HIGH   8'h36
`define RSRB_IDX_WAKE_LOW    8'h37
`define RSRB_IDX_PKT_STATUS  8'h38
`define RSRB_IDX_SYNTH_DAC   8'h39
`define RSRB_IDX_TX_LEVEL    8'h3a
`define RSRB_IDX_RX_LEVEL    8'h3b
`define RSRB_IDX_OSC_ONE     8'h3c
`define RSRB_IDX_OSC_ZERO    8'h3d
// interrupt registers
`define RSRB_IDX_IRQ_STATUS  8'h3e
`define RSRB_IDX_IRQ_MASK    8'h3f

// packet_and_output_status field positions
`define RSRB_PKT_CRC_OK      7
`define RSRB_PKT_CARRIER     6
`define RSRB_PKT_PREAMBLE    5
`define RSRB_PKT_CLEAR       4
`define RSRB_PKT_SYNC        3
`define RSRB_PKT_OUT_TWO     2
`define RSRB_PKT_OUT_ZERO    0

// fifo level fields
`define RSRB_FLAG_BIT        7
`define RSRB_COUNT_MSB       6

// interrupt status bits
`define RSRB_IRQ_SYNC        0
`define RSRB_IRQ_CRC         1
`define RSRB_IRQ_TX_UNDER    2
`define RSRB_IRQ_RX_OVER     3
`define RSRB_IRQ_WIDTH       4

// reset values
`define RSRB_RST_IRQ_MASK    4'h0
`define RSRB_RST_BYTE        8'h00

// axi responses
`define RSRB_RESP_OKAY       2'b00
`define RSRB_RESP_SLVERR     2'b10

`endif

// [rsrb_status_bank.v]
// radio status register bank with axi4-lite slave and interrupt
//
// Operation
// - The wake timer appears as its high byte at 0x36 and its low byte at 0x37.
// - Bit 7 of packet status shows the last crc match and clears on rx entry or restart.
// - Packet status bits 6 to 3 show carrier sense, preamble quality, clear channel, sync found.
// - Bit 2 of packet status shows the non-inverted level of general output two.
// - Bit 0 of packet status shows the non-inverted level of general output zero.
// - The tx level register holds the underflow flag in bit 7 and the byte count in bits 6-0.
// - The rx level register holds the overflow flag in bit 7 and the byte count in bits 6-0.
// - Two registers hold the 7-bit oscillator calibration results with bit 7 reading zero.
// - A read-only register shows the synth calibration dac setting, for test use.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rsrb_regs.vh"

module rsrb_status_bank (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // axi4-lite slave
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // radio core status
    input  wire [15:0] wake_timer_value,
    input  wire        crc_match_pulse,
    input  wire        rx_entry_pulse,
    input  wire        carrier_sense,
    input  wire        preamble_quality_met,
    input  wire        channel_clear_flag,
    input  wire        sync_found_flag,
    input  wire        general_output_two,
    input  wire        output_two_invert,
    input  wire        general_output_zero,
    input  wire        output_zero_invert,
    input  wire [7:0]  synth_cal_dac_setting,
    input  wire        tx_underflow_flag,
    input  wire [6:0]  tx_byte_count,
    input  wire        rx_overflow_flag,
    input  wire [6:0]  rx_byte_count,
    input  wire [6:0]  osc_cal_result_one,
    input  wire [6:0]  osc_cal_result_zero,
    output wire        irq
);

// =====================================================================
// index decode
// =====================================================================
    // a register index from a byte address; low two bits must be zero
    function [7:0] reg_index;
        input [31:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    function addr_ok;
        input [31:0] addr;
        begin
            addr_ok = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h000000);
        end
    endfunction

    // response code from a hit flag, shared by both channels
    function [1:0] resp_of;
        input ok;
        begin
            resp_of = ok ? `RSRB_RESP_OKAY : `RSRB_RESP_SLVERR;
        end
    endfunction

// =====================================================================
// crc match flag
// =====================================================================
    reg crc_ok;
    reg next_crc_ok;

    // rx entry clears
    // entry is checked first so a match in the restart cycle cannot leave a stale flag
    always @* begin
        next_crc_ok = crc_ok;
        if (rx_entry_pulse) begin
            next_crc_ok = 1'b0;
        end else if (crc_match_pulse) begin
            next_crc_ok = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            crc_ok <= 1'b0;
        end else if (clk_en) begin
            crc_ok <= next_crc_ok;
        end
    end

// =====================================================================
// live status composition
// =====================================================================
    wire [7:0] pkt_status;
    // every bit but the crc flag and reserved bit 1 is a live view; only the crc flag has storage

    assign pkt_status[`RSRB_PKT_CRC_OK]   = crc_ok;
    assign pkt_status[`RSRB_PKT_CARRIER]  = carrier_sense;
    assign pkt_status[`RSRB_PKT_PREAMBLE] = preamble_quality_met;
    assign pkt_status[`RSRB_PKT_CLEAR]    = channel_clear_flag;
    assign pkt_status[`RSRB_PKT_SYNC]     = sync_found_flag;
    // output two level
    // the pin level arriving here is already inverted; undo it so software sees raw level
    assign pkt_status[`RSRB_PKT_OUT_TWO]  = general_output_two ^ output_two_invert;
    // reserved bit reads zero
    assign pkt_status[1]                  = 1'b0;
    assign pkt_status[`RSRB_PKT_OUT_ZERO] = general_output_zero ^ output_zero_invert;

// =====================================================================
// interrupt status and mask
// =====================================================================
    reg  [`RSRB_IRQ_WIDTH-1:0] irq_status;
    reg  [`RSRB_IRQ_WIDTH-1:0] irq_mask;
    reg  [`RSRB_IRQ_WIDTH-1:0] prev_events;
    wire [`RSRB_IRQ_WIDTH-1:0] events;
    wire [`RSRB_IRQ_WIDTH-1:0] rise;
    wire                       status_read;

    assign events[`RSRB_IRQ_SYNC]     = sync_found_flag;
    assign events[`RSRB_IRQ_CRC]      = crc_ok;
    assign events[`RSRB_IRQ_TX_UNDER] = tx_underflow_flag;
    assign events[`RSRB_IRQ_RX_OVER]  = rx_overflow_flag;
    assign rise = events & ~prev_events;

    genvar gi;
    generate
        for (gi = 0; gi < `RSRB_IRQ_WIDTH; gi = gi + 1) begin : g_irq
            // event history for edge detection; a level held high sets the bit only once
            always @(posedge aclk) begin
                if (!aresetn) begin
                    prev_events[gi] <= 1'b0;
                end else if (clk_en) begin
                    prev_events[gi] <= events[gi];
                end
            end

            // a new edge wins over the read-clear in the same cycle
            always @(posedge aclk) begin
                if (!aresetn) begin
                    irq_status[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (rise[gi]) begin
                        irq_status[gi] <= 1'b1;
                    end else if (status_read) begin
                        irq_status[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

// =====================================================================
// interrupt output
// =====================================================================
    wire [`RSRB_IRQ_WIDTH-1:0] irq_pending;

    // a level output: it stays high until software reads the status or masks the source
    assign irq_pending = irq_status & irq_mask;
    assign irq         = |irq_pending;

// =====================================================================
// axi write channel
// =====================================================================
    // captured address and data wait here until both halves are in
    reg        aw_held;
    reg        w_held;
    reg [31:0] aw_addr;
    reg [3:0]  w_strb;
    reg [31:0] w_data;
    wire       aw_take;
    wire       w_take;
    wire       b_done;
    wire       wr_go;
    wire       wr_ok;
    wire [7:0] wr_idx;
    wire       wr_in_range;
    wire       wr_to_mask;

    // no new address or data is taken while a response waits, so one write is open at most
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign b_done        = s_axi_bvalid && s_axi_bready;
    assign wr_go         = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = reg_index(aw_addr);
    assign wr_in_range   = (wr_idx >= `RSRB_IDX_WAKE_HIGH) && (wr_idx <= `RSRB_IDX_IRQ_MASK);
    assign wr_ok         = addr_ok(aw_addr) && wr_in_range;
    assign wr_to_mask    = wr_ok && (wr_idx == `RSRB_IDX_IRQ_MASK) && w_strb[0];

    // address half
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h00000000;
        end else if (clk_en) begin
            if (wr_go) begin
                aw_held <= 1'b0;
            end else if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
        end
    end

    // data half
    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_strb <= 4'h0;
            w_data <= 32'h00000000;
        end else if (clk_en) begin
            if (wr_go) begin
                w_held <= 1'b0;
            end else if (w_take) begin
                w_held <= 1'b1;
                w_strb <= s_axi_wstrb;
                w_data <= s_axi_wdata;
            end
        end
    end

    // response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RSRB_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= resp_of(wr_ok);
            end else if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // interrupt mask write; status writes ignored
    // status bytes have no storage on the write side, so a stray write cannot disturb them
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= `RSRB_RST_IRQ_MASK;
        end else if (clk_en) begin
            if (wr_go && wr_to_mask) begin
                irq_mask <= w_data[`RSRB_IRQ_WIDTH-1:0];
            end
        end
    end

// =====================================================================
// axi read channel
// =====================================================================
    reg  [7:0] rd_byte;
    reg        rd_hit;
    wire       rd_take;
    wire       rd_done;
    wire [7:0] rd_idx;

    // one read at a time: the address is refused while its answer is still unread
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;
    assign rd_done       = s_axi_rvalid && s_axi_rready;
    assign rd_idx        = reg_index(s_axi_araddr);
    // a read of the interrupt status clears it at the edge its value is captured
    assign status_read   = rd_take && addr_ok(s_axi_araddr)
                           && rd_idx == `RSRB_IDX_IRQ_STATUS;

    // combinational select; the captured copy lives in rdata
    always @* begin
        rd_hit  = addr_ok(s_axi_araddr);
        rd_byte = `RSRB_RST_BYTE;
        case (rd_idx)
            `RSRB_IDX_WAKE_HIGH:  rd_byte = wake_timer_value[15:8];
            `RSRB_IDX_WAKE_LOW:   rd_byte = wake_timer_value[7:0];
            `RSRB_IDX_PKT_STATUS: rd_byte = pkt_status;
            `RSRB_IDX_SYNTH_DAC:  rd_byte = synth_cal_dac_setting;
            `RSRB_IDX_TX_LEVEL:   rd_byte = {tx_underflow_flag, tx_byte_count};
            `RSRB_IDX_RX_LEVEL:   rd_byte = {rx_overflow_flag, rx_byte_count};
            `RSRB_IDX_OSC_ONE:    rd_byte = {1'b0, osc_cal_result_one};
            `RSRB_IDX_OSC_ZERO:   rd_byte = {1'b0, osc_cal_result_zero};
            `RSRB_IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
            `RSRB_IDX_IRQ_MASK:   rd_byte = {4'h0, irq_mask};
            default:              rd_hit  = 1'b0;
        endcase
    end

    // status is sampled at the address handshake, so counts are live at that edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (clk_en) begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
            end else if (rd_done) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // unmapped or misaligned reads return zero with an error code
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RSRB_RESP_OKAY;
        end else if (clk_en) begin
            if (rd_take) begin
                s_axi_rdata <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
                s_axi_rresp <= resp_of(rd_hit);
            end
        end
    end

endmodule

// [rsrb_status_bank_sva.sv]
// concurrent checks of the radio status register bank at its ports
`timescale 1ns/1ps
module rsrb_status_bank_sva (
    input wire        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready, irq,
    input wire        rx_entry_pulse, carrier_sense, preamble_quality_met,
    input wire        channel_clear_flag, sync_found_flag, general_output_two,
    input wire        output_two_invert, general_output_zero, output_zero_invert,
    input wire [1:0]  s_axi_bresp,
    input wire [31:0] s_axi_awaddr, s_axi_araddr, s_axi_rdata,
    input wire [15:0] wake_timer_value,
    input wire [7:0]  synth_cal_dac_setting,
    input wire [6:0]  tx_byte_count, rx_byte_count, osc_cal_result_one,
    input wire        tx_underflow_flag, rx_overflow_flag
);
    // ==========================================
    // read data follows the inputs seen when the address is taken
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);
    wire rd_go = s_axi_arvalid && s_axi_arready;
    property rd(a, v);
        rd_go && s_axi_araddr == a |=> s_axi_rdata[7:0] == v;
    endproperty
    a_wake_high: assert property (rd(32'hd8, $past(wake_timer_value[15:8])))
        else $error("wake high byte wrong");
    a_wake_low: assert property (rd(32'hdc, $past(wake_timer_value[7:0])))
        else $error("wake low byte wrong");
    a_dac_read: assert property (rd(32'he4, $past(synth_cal_dac_setting)))
        else $error("dac setting wrong");
    a_tx_level: assert property (rd(32'he8, $past({tx_underflow_flag, tx_byte_count})))
        else $error("tx level wrong");
    a_rx_level: assert property (rd(32'hec, $past({rx_overflow_flag, rx_byte_count})))
        else $error("rx level wrong");
    a_osc_one: assert property (rd(32'hf0, $past({1'b0, osc_cal_result_one})))
        else $error("osc result wrong");
    a_pkt_bits: assert property (rd_go && s_axi_araddr == 32'he0 |=>
        s_axi_rdata[6:0] == $past({carrier_sense, preamble_quality_met, channel_clear_flag,
        sync_found_flag, general_output_two ^ output_two_invert, 1'b0,
        general_output_zero ^ output_zero_invert})) else $error("packet status wrong");
    a_crc_clear: assert property (rx_entry_pulse ##1 (rd_go && s_axi_araddr == 32'he0)
        |=> !s_axi_rdata[7]) else $error("crc flag not cleared");
    a_write_okay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr == 32'hd8 |=> ##1 s_axi_bvalid && s_axi_bresp == 2'h0)
        else $error("read-only write not acknowledged");
    c_pkt_read: cover property (rd_go && s_axi_araddr == 32'he0);
    c_write: cover property (s_axi_bvalid);
    c_irq: cover property (irq);
endmodule
bind rsrb_status_bank rsrb_status_bank_sva u_sva (.*);

// [test_radio_status_register_bank.sv]
// self-checking bench of the radio status register bank
`timescale 1ns/1ps
module test_radio_status_register_bank;
    logic        aclk = 0, aresetn = 0, clk_en = 1;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  r;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    logic [15:0] wake_timer_value = 16'ha55c;
    logic        crc_match_pulse = 0, rx_entry_pulse = 0, carrier_sense = 1;
    logic        preamble_quality_met = 0, channel_clear_flag = 1, sync_found_flag = 0;
    logic        general_output_two = 1, output_two_invert = 1;
    logic        general_output_zero = 0, output_zero_invert = 1;
    logic        tx_underflow_flag = 0, rx_overflow_flag = 0;
    logic [7:0]  synth_cal_dac_setting = 8'h9e;
    logic [6:0]  tx_byte_count = 7'h7f, rx_byte_count = 7'h3f;
    logic [6:0]  osc_cal_result_one = 7'h7f, osc_cal_result_zero = 7'h15;
    int          fails = 0, n_compared = 0;
    logic [31:0] ra[12] = '{32'hd8, 32'hdc, 32'he0, 32'he4, 32'he8, 32'hec, 32'hf0,
                            32'hf4, 32'hf8, 32'hfc, 32'h100, 32'hd9};
    logic [7:0]  re[12] = '{8'ha5, 8'h5c, 8'h51, 8'h9e, 8'h7f, 8'h3f, 8'h7f, 8'h15,
                            8'h00, 8'h00, 8'h00, 8'h00};

    rsrb_status_bank uut (.*);

    initial forever #5 aclk = ~aclk;
    // run is about a hundred and ten cycles; far beyond that means a hang
    initial begin
        #200000;
        fails++;
        finish_test;
    end

    // ==========================================
    // bus tasks and comparison
    task automatic chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wr(input logic [31:0] a, v);
        bit ta, tw;
        ta = 0;
        tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end while (!(ta && tw));
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task finish_test;
        $display("compared %0d, errors %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 12; i++) begin
            rd(ra[i]);
            chk(d, {24'h0, re[i]});
            chk(r, i > 9 ? 2'h2 : 2'h0);
        end
        chk(irq, 0);
        wr(32'hd8, 32'hffffffff);
        chk(r, 0);
        rd(32'hd8);
        chk(d, 32'ha5);
        wr(32'h100, 0);
        chk(r, 2'h2);
        @(posedge aclk) rx_byte_count <= 7'h00;
        rd(32'hec);
        chk(d, 0);
        @(posedge aclk) crc_match_pulse <= 1;
        @(posedge aclk) crc_match_pulse <= 0;
        rd(32'he0);
        chk(d, 32'hd1);
        // entry and match together: entry must win
        @(posedge aclk) {rx_entry_pulse, crc_match_pulse} <= 2'h3;
        @(posedge aclk) {rx_entry_pulse, crc_match_pulse} <= 2'h0;
        rd(32'he0);
        chk(d, 32'h51);
        // frozen clock enable: a match while frozen must not reach the flag
        @(posedge aclk) {clk_en, crc_match_pulse} <= 2'h1;
        @(posedge aclk) crc_match_pulse <= 0;
        @(posedge aclk) clk_en <= 1;
        rd(32'he0);
        chk(d, 32'h51);
        rd(32'hf8);
        chk(d, 32'h2);
        rd(32'hf8);
        chk(d, 32'h0);
        wr(32'hfc, 32'hf);
        rd(32'hfc);
        chk(d, 32'hf);
        @(posedge aclk) tx_underflow_flag <= 1;
        repeat (3) @(posedge aclk);
        chk(irq, 1);
        rd(32'he8);
        chk(d, 32'hff);
        rd(32'hf8);
        chk(d, 32'h4);
        repeat (2) @(posedge aclk);
        chk(irq, 0);
        wr(32'hfc, 0);
        @(posedge aclk) rx_overflow_flag <= 1;
        repeat (3) @(posedge aclk);
        chk(irq, 0);
        rd(32'hec);
        chk(d, 32'h80);
        rd(32'hf8);
        chk(d, 32'h8);
        wr(32'hfc, 32'hf);
        // mid-run reset returns mask and status to zero
        @(posedge aclk) aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk(irq, 0);
        rd(32'hfc);
        chk(d, 32'h0);
        finish_test;
    end
endmodule
